/* logic/ust_map.svh */
// register map, field positions, counts and response codes of the serial transmitter
// assumes a 32-bit axi4-lite slave, one aligned word per register
//
// Notes on behaviour
// - nrz frame: start, 8 or 9 data, stops
// - parity on or off, odd or even
// - reset format is 8 data, no parity, one stop
// - lsb first, shared format and baud
// - bit rate clk / (64 or 16 * (n+1))
// - enabled pins serve serial, idle line high
// - disable frees pins, flushes data buffers
// - disable clears enables and break, sets idles
// - disable aborts at once, config kept
// - address detect: msb marks address frame
// - one or two stops, transmitter only
// - ninth bit taken from transmit_bit8
// - shifter reloads only after stop bit sent
// - start needs enable, data and shift tick
// - transmit disable stops and resets transmitter
// - idle write starts at once, busy write held (code waits for the next baud tick to load and start)
// - data writes blocked while ready flag low
// - status access then data write clears flags
// - ready flag set when data register empty
// - idle flag set after stops or break
// - break held long enough sends 13-zero characters
// - break: no interrupt, repeats, ends with stops
`ifndef UST_MAP_SVH
`define UST_MAP_SVH
// ----------------------------------------
// offsets
// ----------------------------------------
`define UST_OFF_CTRL1   5'h00
`define UST_OFF_CTRL2   5'h04
`define UST_OFF_STATUS  5'h08
`define UST_OFF_DATA    5'h0c
`define UST_OFF_BAUD    5'h10
// ----------------------------------------
// field positions
// ----------------------------------------
`define UST_C1_GEN      0
`define UST_C1_WORD9    1
`define UST_C1_PAREN    2
`define UST_C1_PARODD   3
`define UST_C1_STOP2    4
`define UST_C1_BIT8     5
`define UST_C1_ADDR     6
`define UST_C2_TXEN     0
`define UST_C2_RXEN     1
`define UST_C2_BRGH     2
`define UST_C2_BRK      3
`define UST_C2_TEIE     4
`define UST_SR_TXRDY    0
`define UST_SR_TXIDLE   1
`define UST_SR_RXIDLE   2
// ----------------------------------------
// counts and response codes
// ----------------------------------------
`define UST_PRE_LO      6'h3f
`define UST_PRE_HI      4'hf
`define UST_BRK_LAST    4'hc
`define UST_BRK_SAT     9'h1ff
`define UST_RESP_OK     2'h0
`define UST_RESP_ERR    2'h2
`endif

/* logic/ust_pkg.sv */
// types of the serial transmitter: frame states and the whole state record
// enum values and field widths are literals here; ust_map.svh is not used
`default_nettype none
package ust_pkg;
    typedef enum logic [2:0] {
        TX_IDLE  = 3'b000,
        TX_START = 3'b001,
        TX_DATA  = 3'b010,
        TX_PAR   = 3'b011,
        TX_STOP  = 3'b100,
        TX_BRK   = 3'b101
    } ust_tx_t;

    typedef struct packed {
        logic       gen;
        logic       word9;
        logic       par_en;
        logic       par_odd;
        logic       stop2;
        logic       bit8;
        logic       addr_en;
        logic       tx_en;
        logic       rx_en;
        logic       brgh;
        logic       brk;
        logic       teie;
        logic [7:0] divisor;
    } ust_cfg_t;

    typedef struct packed {
        ust_cfg_t   cfg;
        logic       tx_ready;
        logic       tx_idle;
        logic       armed;
        logic [7:0] hold;
        logic       hold_full;
        ust_tx_t    tx;
        logic [8:0] shreg;
        logic       par_bit;
        logic [3:0] bitcnt;
        logic       stopcnt;
        logic [8:0] brk_cnt;
        logic       brk_frame;
        logic [5:0] pre;
        logic [7:0] div;
        logic       tick;
        logic       out;
        logic       aw_got;
        logic       w_got;
        logic [4:0] awaddr;
        logic [7:0] wdata;
        logic       wlane;
        logic       bvalid;
        logic       berr;
        logic       rvalid;
        logic       rerr;
        logic [7:0] rdata;
    } ust_st_t;
endpackage
`default_nettype wire

/* logic/ust_tx.sv */
// serial transmitter with framing, baud divider, break and axi4-lite registers
// assumes synchronous inputs on aclk; receiver data path lives elsewhere
`include "ust_map.svh"
`default_nettype none
module ust_tx (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write
    input  wire logic [4:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [4:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // pins
    output logic             serial_out_pin,
    output logic             serial_out_oe_n,
    output logic             serial_in_claim,
    // request
    output logic             tx_empty_req
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    localparam ust_pkg::ust_st_t ST_RST = '{
        tx: ust_pkg::TX_IDLE,
        tx_ready: 1'b1,
        tx_idle: 1'b1,
        out: 1'b1,
        default: '0
    };

    ust_pkg::ust_st_t st_r;
    ust_pkg::ust_st_t st_nxt;

    logic aw_fire;
    logic w_fire;
    logic ar_fire;
    logic wr_do;
    logic data_wr;
    logic pre_end;
    logic brk_ok;
    logic [8:0] ld_word;

    // register index from a byte address; 7 means unmapped
    function automatic logic [2:0] reg_idx(input logic [4:0] a);
        unique case (a)
            `UST_OFF_CTRL1:  reg_idx = 3'h0;
            `UST_OFF_CTRL2:  reg_idx = 3'h1;
            `UST_OFF_STATUS: reg_idx = 3'h2;
            `UST_OFF_DATA:   reg_idx = 3'h3;
            `UST_OFF_BAUD:   reg_idx = 3'h4;
            default:         reg_idx = 3'h7;
        endcase
    endfunction

    // ----------------------------------------
    // bus handshakes
    // ----------------------------------------
    assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
    assign s_axi_wready  = !st_r.w_got && !st_r.bvalid;
    assign s_axi_arready = !st_r.rvalid;
    assign aw_fire = s_axi_awvalid && s_axi_awready;
    assign w_fire  = s_axi_wvalid && s_axi_wready;
    assign ar_fire = s_axi_arvalid && s_axi_arready;
    assign wr_do   = st_r.aw_got && st_r.w_got;
    assign data_wr = wr_do && st_r.wlane && reg_idx(st_r.awaddr) == 3'h3;

    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp  = st_r.berr ? `UST_RESP_ERR : `UST_RESP_OK;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rresp  = st_r.rerr ? `UST_RESP_ERR : `UST_RESP_OK;
    assign s_axi_rdata  = {24'h00_0000, st_r.rdata};

    // ----------------------------------------
    // pins
    // ----------------------------------------
    assign serial_out_pin  = st_r.out;
    assign serial_out_oe_n = !(st_r.cfg.gen && st_r.cfg.tx_en);
    assign serial_in_claim = st_r.cfg.gen && st_r.cfg.rx_en;
    // break frames never request service
    assign tx_empty_req = st_r.cfg.teie && st_r.tx_ready && !st_r.brk_frame && !st_r.cfg.brk;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    assign pre_end = st_r.cfg.brgh ? (st_r.pre[3:0] == `UST_PRE_HI) : (st_r.pre == `UST_PRE_LO);
    assign brk_ok  = st_r.brk_cnt > ({1'b0, st_r.cfg.divisor} + 9'h001);
    // ninth bit only in 9-bit mode
    assign ld_word = {st_r.cfg.word9 & st_r.cfg.bit8, st_r.hold};

    always_comb begin
        st_nxt = st_r;

        // write channel: address and data in either order
        if (aw_fire) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.awaddr = s_axi_awaddr;
        end
        if (w_fire) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = s_axi_wdata[7:0];
            st_nxt.wlane = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready)
            st_nxt.bvalid = 1'b0;
        if (wr_do) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got  = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.berr   = reg_idx(st_r.awaddr) == 3'h7;
            if (st_r.wlane) begin
                unique case (reg_idx(st_r.awaddr))
                    3'h0: begin
                        st_nxt.cfg.gen     = st_r.wdata[`UST_C1_GEN];
                        st_nxt.cfg.word9   = st_r.wdata[`UST_C1_WORD9];
                        st_nxt.cfg.par_en  = st_r.wdata[`UST_C1_PAREN];
                        st_nxt.cfg.par_odd = st_r.wdata[`UST_C1_PARODD];
                        st_nxt.cfg.stop2   = st_r.wdata[`UST_C1_STOP2];
                        st_nxt.cfg.bit8    = st_r.wdata[`UST_C1_BIT8];
                        st_nxt.cfg.addr_en = st_r.wdata[`UST_C1_ADDR];
                    end
                    3'h1: begin
                        st_nxt.cfg.tx_en = st_r.wdata[`UST_C2_TXEN];
                        st_nxt.cfg.rx_en = st_r.wdata[`UST_C2_RXEN];
                        st_nxt.cfg.brgh  = st_r.wdata[`UST_C2_BRGH];
                        st_nxt.cfg.brk   = st_r.wdata[`UST_C2_BRK];
                        st_nxt.cfg.teie  = st_r.wdata[`UST_C2_TEIE];
                    end
                    3'h3: begin
                        // only after a status access and while ready
                        if (st_r.armed && st_r.tx_ready && st_r.cfg.gen) begin
                            st_nxt.hold      = st_r.wdata;
                            st_nxt.hold_full = 1'b1;
                            st_nxt.tx_ready  = 1'b0;
                            st_nxt.tx_idle   = 1'b0;
                            st_nxt.armed     = 1'b0;
                        end
                    end
                    3'h4: st_nxt.cfg.divisor = st_r.wdata;
                    default: ;
                endcase
            end
        end

        // read channel; a status read arms the flag-clearing sequence
        if (s_axi_rvalid && s_axi_rready)
            st_nxt.rvalid = 1'b0;
        if (ar_fire) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rerr   = 1'b0;
            st_nxt.rdata  = 8'h00;
            unique case (reg_idx(s_axi_araddr))
                3'h0: st_nxt.rdata = {1'b0, st_r.cfg.addr_en, st_r.cfg.bit8, st_r.cfg.stop2,
                                      st_r.cfg.par_odd, st_r.cfg.par_en, st_r.cfg.word9, st_r.cfg.gen};
                3'h1: st_nxt.rdata = {3'h0, st_r.cfg.teie, st_r.cfg.brk, st_r.cfg.brgh,
                                      st_r.cfg.rx_en, st_r.cfg.tx_en};
                3'h2: begin
                    // receiver flags read zero here; receiver reports idle
                    st_nxt.rdata = {5'h00, 1'b1, st_r.tx_idle, st_r.tx_ready};
                    st_nxt.armed = 1'b1;
                end
                3'h3: st_nxt.rdata = st_r.hold;
                3'h4: st_nxt.rdata = st_r.cfg.divisor;
                default: st_nxt.rerr = 1'b1;
            endcase
        end

        // break hold timer
        if (!st_r.cfg.brk)
            st_nxt.brk_cnt = 9'h000;
        else if (st_r.brk_cnt != `UST_BRK_SAT)
            st_nxt.brk_cnt = st_r.brk_cnt + 9'h001;

        // baud generator: prescale 64 or 16, then divisor+1
        st_nxt.tick = 1'b0;
        if (!st_r.cfg.gen) begin
            st_nxt.pre = 6'h00;
            st_nxt.div = 8'h00;
        end else begin
            st_nxt.pre = pre_end ? 6'h00 : st_r.pre + 6'h01;
            if (pre_end) begin
                if (st_r.div == 8'h00) begin
                    st_nxt.tick = 1'b1;
                    st_nxt.div  = st_r.cfg.divisor;
                end else
                    st_nxt.div = st_r.div - 8'h01;
            end
        end

        // frame sequencer, advances one bit per tick
        if (st_r.tick && st_r.cfg.tx_en) begin
            unique case (st_r.tx)
                ust_pkg::TX_IDLE: begin
                    if (brk_ok) begin
                        st_nxt.brk_frame = 1'b1;
                        st_nxt.tx        = ust_pkg::TX_START;
                        st_nxt.out       = 1'b0;
                    end else if (st_r.hold_full) begin
                        st_nxt.shreg     = ld_word;
                        st_nxt.par_bit   = ^ld_word ^ st_r.cfg.par_odd;
                        st_nxt.hold_full = 1'b0;
                        st_nxt.tx_ready  = 1'b1;
                        st_nxt.tx        = ust_pkg::TX_START;
                        st_nxt.out       = 1'b0;
                    end
                end
                ust_pkg::TX_START: begin
                    st_nxt.bitcnt = 4'h0;
                    if (st_r.brk_frame) begin
                        st_nxt.tx  = ust_pkg::TX_BRK;
                        st_nxt.out = 1'b0;
                    end else begin
                        st_nxt.tx  = ust_pkg::TX_DATA;
                        st_nxt.out = st_r.shreg[0];
                    end
                end
                ust_pkg::TX_DATA: begin
                    // in 9-bit mode the last data bit is bit8, the address marker; addr_en does not change it
                    if (st_r.bitcnt == (st_r.cfg.word9 ? 4'h8 : 4'h7)) begin
                        st_nxt.stopcnt = 1'b0;
                        st_nxt.tx      = st_r.cfg.par_en ? ust_pkg::TX_PAR : ust_pkg::TX_STOP;
                        st_nxt.out     = st_r.cfg.par_en ? st_r.par_bit : 1'b1;
                    end else begin
                        st_nxt.shreg  = {1'b0, st_r.shreg[8:1]};
                        st_nxt.out    = st_r.shreg[1];
                        st_nxt.bitcnt = st_r.bitcnt + 4'h1;
                    end
                end
                ust_pkg::TX_PAR: begin
                    st_nxt.stopcnt = 1'b0;
                    st_nxt.tx      = ust_pkg::TX_STOP;
                    st_nxt.out     = 1'b1;
                end
                ust_pkg::TX_STOP: begin
                    if (st_r.cfg.stop2 && !st_r.stopcnt)
                        st_nxt.stopcnt = 1'b1;
                    else begin
                        st_nxt.tx        = ust_pkg::TX_IDLE;
                        st_nxt.tx_idle   = 1'b1;
                        st_nxt.brk_frame = 1'b0;
                    end
                end
                ust_pkg::TX_BRK: begin
                    if (st_r.bitcnt == `UST_BRK_LAST) begin
                        st_nxt.bitcnt = 4'h0;
                        if (!st_r.cfg.brk) begin
                            st_nxt.stopcnt = 1'b0;
                            st_nxt.tx      = ust_pkg::TX_STOP;
                            st_nxt.out     = 1'b1;
                        end
                    end else
                        st_nxt.bitcnt = st_r.bitcnt + 4'h1;
                end
                default: st_nxt.tx = ust_pkg::TX_IDLE;
            endcase
        end

        // transmit disable resets the sequencer mid-frame
        if (!st_nxt.cfg.tx_en) begin
            st_nxt.tx        = ust_pkg::TX_IDLE;
            st_nxt.out       = 1'b1;
            st_nxt.brk_frame = 1'b0;
        end

        // global disable: abort, flush, clear enables and break, set idles; other config kept
        if (!st_nxt.cfg.gen) begin
            st_nxt.cfg.tx_en = 1'b0;
            st_nxt.cfg.rx_en = 1'b0;
            st_nxt.cfg.brk   = 1'b0;
            st_nxt.hold_full = 1'b0;
            st_nxt.tx_ready  = 1'b1;
            st_nxt.tx_idle   = 1'b1;
            st_nxt.tx        = ust_pkg::TX_IDLE;
            st_nxt.out       = 1'b1;
            st_nxt.brk_frame = 1'b0;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn)
            st_r <= ST_RST;
        else
            st_r <= st_nxt;
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_idle_high;
        st_r.tx == ust_pkg::TX_IDLE |-> st_r.out;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("line not high while idle");

    property p_fmt_reset;
        $past(!aresetn) |-> !st_r.cfg.word9 && !st_r.cfg.par_en && !st_r.cfg.stop2;
    endproperty
    a_fmt_reset: assert property (p_fmt_reset) else $error("format not 8n1 after reset");

    property p_disable;
        !st_r.cfg.gen |-> st_r.tx_ready && st_r.tx_idle && !st_r.cfg.tx_en && !st_r.hold_full;
    endproperty
    a_disable: assert property (p_disable) else $error("disable left flags or data");

    // ready may rise on the same edge when a load tick coincides with the refused write
    property p_block;
        data_wr && !st_r.tx_ready |=> $stable(st_r.hold) && (!st_r.tx_ready || $past(st_r.tick));
    endproperty
    a_block: assert property (p_block) else $error("write accepted while not ready");

    // a frame ending on the same edge sets idle again; the set wins
    property p_clear_seq;
        data_wr && st_r.armed && st_r.tx_ready && st_r.cfg.gen |=> st_r.hold_full
            && (!st_r.tx_idle || $past(st_r.tick && st_r.tx == ust_pkg::TX_STOP));
    endproperty
    a_clear_seq: assert property (p_clear_seq) else $error("sequence did not clear flags");

    property p_brk_low;
        st_r.tx == ust_pkg::TX_BRK |-> !st_r.out && !tx_empty_req;
    endproperty
    a_brk_low: assert property (p_brk_low) else $error("break frame not low or requests");

    // only windows with untouched settings, since a settings write can change the spacing
    property p_tick_hi;
        st_r.tick && st_r.cfg.brgh && st_r.cfg.divisor == 8'h00 && st_r.div == 8'h00 && $stable(st_r.cfg)
            ##1 $stable(st_r.cfg) [*8] ##1 $stable(st_r.cfg) [*7] |=> st_r.tick;
    endproperty
    a_tick_hi: assert property (p_tick_hi) else $error("fast baud tick spacing wrong");

    property p_txen_off;
        !st_r.cfg.tx_en |-> st_r.tx == ust_pkg::TX_IDLE && st_r.out;
    endproperty
    a_txen_off: assert property (p_txen_off) else $error("transmitter runs while disabled");

    property p_start;
        st_r.tx == ust_pkg::TX_IDLE ##1 st_r.tx == ust_pkg::TX_START |-> !st_r.out && $past(st_r.tick);
    endproperty
    a_start: assert property (p_start) else $error("start not low or not on tick");

    // a frame cut by transmit disable never completed
    property p_idle_set;
        st_r.tx == ust_pkg::TX_STOP ##1 st_r.tx == ust_pkg::TX_IDLE && st_r.cfg.tx_en |-> st_r.tx_idle;
    endproperty
    a_idle_set: assert property (p_idle_set) else $error("idle flag not set after stop");

    property p_load;
        st_r.tx == ust_pkg::TX_IDLE && st_r.tick && st_r.cfg.tx_en && st_r.hold_full && !brk_ok && !wr_do
            |=> st_r.tx == ust_pkg::TX_START && st_r.tx_ready && !st_r.hold_full && !st_r.out;
    endproperty
    a_load: assert property (p_load) else $error("held word not moved to shifter");

    property p_stop_high;
        st_r.tx == ust_pkg::TX_STOP |-> st_r.out;
    endproperty
    a_stop_high: assert property (p_stop_high) else $error("stop bit not high");

    property p_first_bit;
        st_r.tx == ust_pkg::TX_START && st_r.tick && st_r.cfg.tx_en && !st_r.brk_frame && !wr_do
            |=> st_r.tx == ust_pkg::TX_DATA && st_r.out == st_r.shreg[0];
    endproperty
    a_first_bit: assert property (p_first_bit) else $error("first data bit not lsb");
endmodule
`default_nettype wire

/* test/ust_rx_model.sv */
// remote serial receiver model watching the transmit line
// assumes the bench sets bit length and bit count between frames
`default_nettype none
module ust_rx_model (
    // clock and line
    input  wire logic        aclk,
    input  wire logic        line,
    // frame shape
    input  wire logic [15:0] bit_len,
    input  wire logic [3:0]  nbits,
    // results
    output var  logic [12:0] word,
    output var  logic        stop_ok,
    output var  logic [7:0]  count,
    output var  logic [15:0] period
);
    timeunit 1ns;
    timeprecision 1ns;
    int t = 0;
    int t0 = 0;
    always @(posedge aclk) t <= t + 1;
    // ----
    // framing: start, bits lsb first, one stop sampled mid bit
    // ----
    initial begin
        word = '0;
        stop_ok = 1'b0;
        count = '0;
        period = '0;
        forever begin
            @(negedge line);
            period = 16'(t - t0);
            t0 = t;
            word = '0;
            repeat (bit_len / 2) @(posedge aclk);
            for (int i = 0; i < nbits; i++) begin
                repeat (bit_len) @(posedge aclk);
                word[i] = line;
            end
            repeat (bit_len) @(posedge aclk);
            stop_ok = line;
            count = count + 8'h01;
            wait (line);
        end
    end
endmodule
`default_nettype wire

/* test/tb_ust_tx.sv */
// self-checking bench of the serial transmitter over axi4-lite
// assumes the ust_tx register map and a 50 ns aclk
`include "ust_map.svh"
`default_nettype none
module tb_ust_tx;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [4:0]  awaddr = '0, araddr = '0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0, rdata, rd;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, r;
    logic        pin, oe_n, claim, req, stop_ok;
    logic [15:0] bit_len = 16'h0010, period;
    logic [3:0]  nbits = 4'h8;
    logic [12:0] word;
    logic [7:0]  count;
    int          errors = 0, checked = 0;
    localparam logic [7:0]  C1 [6] = '{8'h01, 8'h05, 8'h0d, 8'h23, 8'h27, 8'h01};
    localparam logic [3:0]  NB [6] = '{4'h8, 4'h9, 4'h9, 4'h9, 4'ha, 4'h8};
    localparam logic [12:0] EX [6] = '{13'h0096, 13'h0096, 13'h0196, 13'h0196, 13'h0396, 13'h0081};
    always #25 aclk = ~aclk;
    ust_tx i_ust_tx (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .serial_out_pin(pin), .serial_out_oe_n(oe_n), .serial_in_claim(claim), .tx_empty_req(req));
    // released line rests on its pull-up
    ust_rx_model i_ust_rx_model (.aclk(aclk), .line(oe_n ? 1'b1 : pin), .bit_len(bit_len), .nbits(nbits),
        .word(word), .stop_ok(stop_ok), .count(count), .period(period));
    // ----
    // bus tasks; ready sampled mid cycle, signals moved after the edge
    // ----
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus_wr(input logic [4:0] a, input logic [7:0] d);
        logic ta, tw, tb;
        int n;
        n = 0;
        tb = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h00_0000, d};
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!tb && n < 200) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            n++;
        end
        bready <= 1'b0;
        if (!tb) errors++;
    endtask
    task automatic bus_rd(input logic [4:0] a);
        logic ta, tr;
        int n;
        n = 0;
        tr = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!tr && n < 200) begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid;
            rd = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            n++;
        end
        rready <= 1'b0;
        if (!tr) errors++;
    endtask
    task automatic send(input logic [7:0] d);
        bus_rd(`UST_OFF_STATUS);
        bus_wr(`UST_OFF_DATA, d);
    endtask
    task automatic wait_rx(input logic [7:0] n);
        int k;
        k = 0;
        while (count != n && k < 5000) begin
            @(posedge aclk);
            k++;
        end
        chk(32'(count), 32'(n));
    endtask
    task automatic end_sim();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ----
    // scenarios
    // ----
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        bus_rd(`UST_OFF_STATUS);
        chk(rd, 32'h0000_0007);
        bus_rd(`UST_OFF_CTRL1);
        chk(rd, 32'h0000_0000);
        chk({30'h0, pin, oe_n}, 32'h0000_0003);
        bus_rd(5'h14);
        chk({rd[29:0], r}, 32'h0000_0002);
        bus_wr(5'h18, 8'hff);
        chk(32'(r), 32'h0000_0002);
        bus_wr(`UST_OFF_BAUD, 8'h00);
        chk(32'(r), 32'h0000_0000);
        // global enable first: a disabled port keeps transmit enable clear
        bus_wr(`UST_OFF_CTRL1, 8'h11);
        bus_wr(`UST_OFF_CTRL2, 8'h07);
        chk({30'h0, claim, oe_n}, 32'h0000_0002);
        send(8'ha5);
        repeat (40) @(posedge aclk);
        send(8'h5a); // held behind the running frame
        send(8'hff); // ready low, must not land
        wait_rx(8'h01);
        chk(32'(word), 32'h0000_00a5);
        wait_rx(8'h02);
        chk(32'(word), 32'h0000_005a);
        // 11 frame bits plus the idle tick before the held word loads
        chk(32'(period), 32'h0000_00c0);
        send(8'hc3);
        wait_rx(8'h03);
        bus_wr(`UST_OFF_DATA, 8'h77); // no status access before it
        repeat (400) @(posedge aclk);
        chk(32'(count), 32'h0000_0003);
        bus_rd(`UST_OFF_STATUS);
        chk(rd, 32'h0000_0007);
        for (int i = 0; i < 6; i++) begin
            bus_wr(`UST_OFF_BAUD, (i == 5) ? 8'h01 : 8'h00);
            bus_wr(`UST_OFF_CTRL2, (i == 5) ? 8'h03 : 8'h07);
            bus_wr(`UST_OFF_CTRL1, C1[i]);
            bit_len <= (i == 5) ? 16'h0080 : 16'h0010;
            nbits <= NB[i];
            send((i == 5) ? 8'h81 : 8'h96);
            wait_rx(8'(4 + i));
            chk({19'h0, word}, {19'h0, EX[i]});
            repeat (100) @(posedge aclk);
        end
        bus_wr(`UST_OFF_BAUD, 8'h00);
        bus_wr(`UST_OFF_CTRL2, 8'h1f);
        bit_len <= 16'h0010;
        nbits <= 4'hd;
        repeat (60) @(posedge aclk);
        chk({30'h0, req, pin}, 32'h0000_0000);
        bus_wr(`UST_OFF_CTRL2, 8'h17);
        wait_rx(8'h0a);
        chk({18'h0, stop_ok, word}, 32'h0000_2000);
        repeat (40) @(posedge aclk);
        chk(32'(req), 32'h0000_0001);
        nbits <= 4'h8;
        send(8'h00);
        repeat (60) @(posedge aclk);
        bus_wr(`UST_OFF_CTRL2, 8'h06);
        chk({30'h0, pin, oe_n}, 32'h0000_0003);
        repeat (300) @(posedge aclk);
        send(8'h3c);
        repeat (100) @(posedge aclk);
        chk(32'(count), 32'h0000_000b);
        bus_wr(`UST_OFF_CTRL2, 8'h07);
        wait_rx(8'h0c);
        chk(32'(word), 32'h0000_003c);
        bus_wr(`UST_OFF_BAUD, 8'h03);
        bus_wr(`UST_OFF_CTRL1, 8'h1c);
        bus_rd(`UST_OFF_CTRL2);
        chk(rd, 32'h0000_0004);
        bus_rd(`UST_OFF_STATUS);
        chk(rd, 32'h0000_0007);
        bus_rd(`UST_OFF_CTRL1);
        chk(rd, 32'h0000_001c);
        bus_rd(`UST_OFF_BAUD);
        chk(rd, 32'h0000_0003);
        chk({30'h0, claim, oe_n}, 32'h0000_0001);
        end_sim();
    end
    initial begin
        repeat (30000) @(posedge aclk);
        errors++;
        end_sim();
    end
endmodule
`default_nettype wire
